/* File: logic/igo_pkg.sv */
/*
 * package for the input route, gain and offset register group:
 * register offsets, reset values, field positions, mode enums and carriers.
 * assumes nothing of its surroundings.
 */
`default_nettype none

package igo_pkg;

	// ==========================================
	// register offsets
	localparam logic [7:0] IGO_ADDR_INSEL = 8'h19;
	localparam logic [7:0] IGO_ADDR_FILT = 8'h1A;
	localparam logic [7:0] IGO_ADDR_BGGAIN = 8'h1B;
	localparam logic [7:0] IGO_ADDR_RGAIN = 8'h1C;
	localparam logic [7:0] IGO_ADDR_FINELO = 8'h1D;

	// ==========================================
	// reset values
	localparam logic [7:0] IGO_RST_INSEL = 8'h00;
	localparam logic [7:0] IGO_RST_FILT = 8'hC2;
	localparam logic [7:0] IGO_RST_BGGAIN = 8'h77;
	localparam logic [7:0] IGO_RST_RGAIN = 8'h07;
	localparam logic [7:0] IGO_RST_FINELO = 8'h00;

	// ==========================================
	// field positions (lsb of each field)
	localparam int IGO_FILT_SOG = 6;
	localparam int IGO_FILT_CLP = 4;
	localparam int IGO_FILT_CLK = 3;
	localparam int IGO_FILT_VS = 2;
	localparam int IGO_FILT_PCLK = 1;
	localparam int IGO_FILT_HS = 0;
	localparam int IGO_INSEL_SOG = 6;
	localparam int IGO_INSEL_RED = 4;
	localparam int IGO_INSEL_GRN = 2;
	localparam int IGO_INSEL_BLU = 0;
	localparam int IGO_GAIN_HI = 4;
	localparam int IGO_GAIN_LO = 0;
	localparam logic [7:0] IGO_RGAIN_MASK = 8'h0F;
	localparam logic [7:0] IGO_FINELO_MASK = 8'h3F;

	// ==========================================
	// codes and datapath constants
	localparam logic [1:0] IGO_SRC_RSVD = 2'h3;
	localparam logic [4:0] IGO_GAIN_BASE_TENTHS = 5'h05;
	localparam logic [11:0] IGO_OFS_ZERO = 12'h200;
	localparam logic [11:0] IGO_ADC_MAX = 12'h3FF;
	localparam int IGO_NCH = 3;

	// ==========================================
	// modes
	typedef enum logic [1:0] {
		IGO_SOG_2M5,
		IGO_SOG_10M,
		IGO_SOG_33M,
		IGO_SOG_BYPASS
	} igo_sog_filt_t;

	typedef enum logic [1:0] {
		IGO_CLP_4M8,
		IGO_CLP_0M5,
		IGO_CLP_1M7
	} igo_clp_filt_t;

	// ==========================================
	// carriers
	typedef struct packed {
		logic sync_ref_ext;
		logic vertical_sync_input_choice_b;
		logic horizontal_sync_input_choice_b;
		logic adc_clk_pll;
	} igo_route_t;

	typedef struct packed {
		logic [3:0] code;
		logic [4:0] tenths;
	} igo_gain_t;

endpackage

`default_nettype wire

/* File: logic/igo_fine_offset.sv */
/*
 * one channel of the digital fine offset stage after the adc.
 * assumes adc samples arrive synchronous to clk with a valid strobe.
 */
`timescale 1ns/1ps
`default_nettype none

module igo_fine_offset #(
	parameter int W = 10
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// sample in
	input wire logic valid_i,
	input wire logic [W-1:0] data_i,
	input wire logic [W-1:0] offset_i,
	// sample out
	output logic valid_o,
	output logic [W-1:0] data_o
);

	logic [11:0] sum;

	// offset binary: mid code adds nothing, result clipped to adc range
	assign sum = 12'(data_i) + 12'(offset_i) - igo_pkg::IGO_OFS_ZERO;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			valid_o <= 1'b0;
		end else begin
			valid_o <= valid_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			data_o <= '0;
		end else if (valid_i) begin
			if (sum[11]) begin
				data_o <= '0;
			end else if (sum > igo_pkg::IGO_ADC_MAX) begin
				data_o <= '1;
			end else begin
				data_o <= sum[W-1:0];
			end
		end
	end

endmodule // igo_fine_offset

`default_nettype wire

/* File: logic/igo_regs.sv */
/*
 * input route, filter, clock select, coarse gain and fine offset register
 * group of a triple video digitizer, with the fine offset datapath.
 * assumes the serial control port has been decoded into byte writes and
 * reads on clk_i, and that the fine offset high bytes come from elsewhere.
 */
// Function
// R1: sync-on-green filter code picks bandwidth, 11 bypass
// R2: clamp filter code picks bandwidth, 11 reserved
// R3: sync processing reference internal or external
// R4: control, separator, activity always internal reference
// R5: system should supply accurate external reference
// R6: vertical sync input a or b
// R7: horizontal sync input a or b
// R8: adc clock external or pll, pll default
// R9: software pairs external clock with external clamp
// R10: gain is 0.5 plus 0.1 per step
// R11: green high, blue low nibble, reset 77h
// R12: red gain low nibble, resets 07h
// R13: software limits gain for 700 mV input
// R14: red fine offset low bits at 5:4
// R15: green fine offset low bits at 3:2
// R16: blue fine offset low bits at 1:0
// R17: four 2-bit input source selects, reset 00
// R18: filter register resets C2h, fields read back
`timescale 1ns/1ps
`default_nettype none

module igo_regs #(
	parameter int ADC_W = 10
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// register port
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	// sync inputs
	input wire logic vsync_a_i,
	input wire logic vsync_b_i,
	input wire logic hsync_a_i,
	input wire logic hsync_b_i,
	output logic vsync_o,
	output logic hsync_o,
	// analog front end controls
	output logic [1:0] sog_src_o,
	output logic [1:0] red_src_o,
	output logic [1:0] grn_src_o,
	output logic [1:0] blu_src_o,
	output igo_pkg::igo_sog_filt_t sog_filt_o,
	output igo_pkg::igo_clp_filt_t clp_filt_o,
	output igo_pkg::igo_route_t route_o,
	output logic ctrl_ref_ext_o,
	output igo_pkg::igo_gain_t red_gain_o,
	output igo_pkg::igo_gain_t grn_gain_o,
	output igo_pkg::igo_gain_t blu_gain_o,
	// fine offset datapath, index 0 blue, 1 green, 2 red
	input wire logic [igo_pkg::IGO_NCH-1:0][7:0] fine_hi_i,
	input wire logic adc_valid_i,
	input wire logic [igo_pkg::IGO_NCH-1:0][ADC_W-1:0] adc_data_i,
	output logic [igo_pkg::IGO_NCH-1:0] out_valid_o,
	output logic [igo_pkg::IGO_NCH-1:0][ADC_W-1:0] out_data_o
);

	logic [7:0] insel_r, filt_r, bggain_r, rgain_r, finelo_r;
	logic [igo_pkg::IGO_NCH-1:0][ADC_W-1:0] fine_ofs;

	// ==========================================
	// register writes
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			insel_r <= igo_pkg::IGO_RST_INSEL; // [R17]
			filt_r <= igo_pkg::IGO_RST_FILT; // [R18]
			bggain_r <= igo_pkg::IGO_RST_BGGAIN; // [R11]
			rgain_r <= igo_pkg::IGO_RST_RGAIN; // [R12]
			finelo_r <= igo_pkg::IGO_RST_FINELO;
		end else if (reg_we_i) begin
			unique case (reg_addr_i)
				igo_pkg::IGO_ADDR_INSEL: insel_r <= reg_wdata_i;
				igo_pkg::IGO_ADDR_FILT: filt_r <= reg_wdata_i;
				igo_pkg::IGO_ADDR_BGGAIN: bggain_r <= reg_wdata_i;
				igo_pkg::IGO_ADDR_RGAIN: rgain_r <= reg_wdata_i & igo_pkg::IGO_RGAIN_MASK;
				igo_pkg::IGO_ADDR_FINELO: finelo_r <= reg_wdata_i & igo_pkg::IGO_FINELO_MASK;
				default: ;
			endcase
		end
	end

	// ==========================================
	// read back, one cycle after the read strobe
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_re_i) begin
			unique case (reg_addr_i)
				igo_pkg::IGO_ADDR_INSEL: reg_rdata_o <= insel_r;
				igo_pkg::IGO_ADDR_FILT: reg_rdata_o <= filt_r;
				igo_pkg::IGO_ADDR_BGGAIN: reg_rdata_o <= bggain_r; // [R18]
				igo_pkg::IGO_ADDR_RGAIN: reg_rdata_o <= rgain_r; // [R18]
				igo_pkg::IGO_ADDR_FINELO: reg_rdata_o <= finelo_r; // [R18]
				default: reg_rdata_o <= 8'h00;
			endcase
		end
	end

	// ==========================================
	// input source selects; reserved codes keep the last legal source, except green, which takes code 11 as written
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			sog_src_o <= 2'h0;
			red_src_o <= 2'h0;
			grn_src_o <= 2'h0;
			blu_src_o <= 2'h0;
		end else begin
			if (insel_r[igo_pkg::IGO_INSEL_SOG +: 2] != igo_pkg::IGO_SRC_RSVD) begin
				sog_src_o <= insel_r[igo_pkg::IGO_INSEL_SOG +: 2]; // [R17]
			end
			if (insel_r[igo_pkg::IGO_INSEL_RED +: 2] != igo_pkg::IGO_SRC_RSVD) begin
				red_src_o <= insel_r[igo_pkg::IGO_INSEL_RED +: 2]; // [R17]
			end
			grn_src_o <= insel_r[igo_pkg::IGO_INSEL_GRN +: 2]; // [R17]
			if (insel_r[igo_pkg::IGO_INSEL_BLU +: 2] != igo_pkg::IGO_SRC_RSVD) begin
				blu_src_o <= insel_r[igo_pkg::IGO_INSEL_BLU +: 2]; // [R17]
			end
		end
	end

	// ==========================================
	// filters; a reserved clamp code keeps the last legal bandwidth
	assign sog_filt_o = igo_pkg::igo_sog_filt_t'(filt_r[igo_pkg::IGO_FILT_SOG +: 2]); // [R1]

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			clp_filt_o <= igo_pkg::IGO_CLP_4M8;
		end else if (filt_r[igo_pkg::IGO_FILT_CLP +: 2] != igo_pkg::IGO_SRC_RSVD) begin
			clp_filt_o <= igo_pkg::igo_clp_filt_t'(filt_r[igo_pkg::IGO_FILT_CLP +: 2]); // [R2]
		end
	end

	// ==========================================
	// clock and sync routing
	always_comb begin
		route_o.sync_ref_ext = filt_r[igo_pkg::IGO_FILT_CLK]; // [R3]
		route_o.vertical_sync_input_choice_b = filt_r[igo_pkg::IGO_FILT_VS];
		route_o.horizontal_sync_input_choice_b = filt_r[igo_pkg::IGO_FILT_HS];
		route_o.adc_clk_pll = filt_r[igo_pkg::IGO_FILT_PCLK]; // [R8]
	end

	// control port, separator and activity logic never follow the select
	assign ctrl_ref_ext_o = 1'b0; // [R4]

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			vsync_o <= 1'b0;
			hsync_o <= 1'b0;
		end else begin
			vsync_o <= filt_r[igo_pkg::IGO_FILT_VS] ? vsync_b_i : vsync_a_i; // [R6]
			hsync_o <= filt_r[igo_pkg::IGO_FILT_HS] ? hsync_b_i : hsync_a_i; // [R7]
		end
	end

	// ==========================================
	// coarse gains in tenths: 5 + code
	always_comb begin
		grn_gain_o.code = bggain_r[igo_pkg::IGO_GAIN_HI +: 4]; // [R11]
		blu_gain_o.code = bggain_r[igo_pkg::IGO_GAIN_LO +: 4]; // [R11]
		red_gain_o.code = rgain_r[igo_pkg::IGO_GAIN_LO +: 4]; // [R12]
		grn_gain_o.tenths = igo_pkg::IGO_GAIN_BASE_TENTHS + 5'(grn_gain_o.code); // [R10]
		blu_gain_o.tenths = igo_pkg::IGO_GAIN_BASE_TENTHS + 5'(blu_gain_o.code); // [R10]
		red_gain_o.tenths = igo_pkg::IGO_GAIN_BASE_TENTHS + 5'(red_gain_o.code); // [R10]
	end

	// ==========================================
	// fine offset, channel c low bits at finelo_r[2c+1:2c]
	genvar c;
	generate
		for (c = 0; c < igo_pkg::IGO_NCH; c++) begin : g_ch
			assign fine_ofs[c] = ADC_W'({fine_hi_i[c], finelo_r[2*c +: 2]}); // [R14] [R15] [R16]
			igo_fine_offset #(
				.W(ADC_W)
			) u_ofs (
				.clk_i(clk_i),
				.srst_i(srst_i),
				.valid_i(adc_valid_i),
				.data_i(adc_data_i[c]),
				.offset_i(fine_ofs[c]),
				.valid_o(out_valid_o[c]),
				.data_o(out_data_o[c])
			);
		end
	endgenerate

	// ==========================================
	// assertions
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	reset_filt_a: assert property ($past(srst_i) |-> filt_r == igo_pkg::IGO_RST_FILT
		&& bggain_r == igo_pkg::IGO_RST_BGGAIN) // [R18]
		else $error("reset value wrong");
	sog_filt_a: assert property (reg_we_i && reg_addr_i == igo_pkg::IGO_ADDR_FILT |=>
		sog_filt_o == igo_pkg::igo_sog_filt_t'($past(reg_wdata_i[7:6]))) // [R1]
		else $error("sog filter not applied");
	clp_hold_a: assert property (reg_we_i && reg_addr_i == igo_pkg::IGO_ADDR_FILT
		&& reg_wdata_i[5:4] == 2'h3 |=> ##1 clp_filt_o == $past(clp_filt_o, 2)) // [R2]
		else $error("reserved clamp code applied");
	adc_clk_a: assert property (reg_we_i && reg_addr_i == igo_pkg::IGO_ADDR_FILT |=>
		route_o.adc_clk_pll == $past(reg_wdata_i[1])
		&& route_o.sync_ref_ext == $past(reg_wdata_i[3])) // [R8]
		else $error("clock select not applied");
	hs_route_a: assert property (route_o.horizontal_sync_input_choice_b |=> hsync_o == $past(hsync_b_i)) // [R7]
		else $error("hsync route wrong");
	vs_route_a: assert property (!route_o.vertical_sync_input_choice_b |=> vsync_o == $past(vsync_a_i)) // [R6]
		else $error("vsync route wrong");
	grn_gain_a: assert property (reg_we_i && reg_addr_i == igo_pkg::IGO_ADDR_BGGAIN |=>
		grn_gain_o.tenths == 5'h05 + 5'($past(reg_wdata_i[7:4]))) // [R10]
		else $error("green gain wrong");
	red_rsvd_a: assert property (reg_re_i && reg_addr_i == igo_pkg::IGO_ADDR_RGAIN |=>
		reg_rdata_o[7:4] == 4'h0) // [R12]
		else $error("red gain reserved bits set");
	readback_a: assert property (reg_we_i && reg_addr_i == igo_pkg::IGO_ADDR_FINELO ##1
		!reg_we_i ##1 reg_re_i && !reg_we_i && reg_addr_i == igo_pkg::IGO_ADDR_FINELO |=>
		reg_rdata_o == ($past(reg_wdata_i, 3) & 8'h3F)) // [R14]
		else $error("fine offset readback wrong");
	grn_src_a: assert property (reg_we_i && reg_addr_i == igo_pkg::IGO_ADDR_INSEL |=>
		##1 grn_src_o == $past(reg_wdata_i[3:2], 2)) // [R17]
		else $error("green source not applied");

	bypass_c: cover property (sog_filt_o == igo_pkg::IGO_SOG_BYPASS ##1
		sog_filt_o == igo_pkg::IGO_SOG_2M5);
	external_clock_input_c: cover property (!route_o.adc_clk_pll && !route_o.sync_ref_ext);
	rsvd_clp_c: cover property (filt_r[5:4] == 2'h3);
	clip_c: cover property (adc_valid_i ##1 out_data_o[2] == '1);

endmodule // igo_regs

`default_nettype wire

/* File: sim/igo_host_model.sv */
/*
 * host model for the register port of the input route, gain and offset group.
 * assumes a free running clk_i and one caller at a time; strobes last one cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module igo_host_model (
	// clock
	input wire logic clk_i,
	// register port
	output logic reg_we_o,
	output logic reg_re_o,
	output logic [7:0] reg_addr_o,
	output logic [7:0] reg_wdata_o,
	input wire logic [7:0] reg_rdata_i
);
	// ==========================================
	// requests
	initial {reg_we_o, reg_re_o, reg_addr_o, reg_wdata_o} = '0;

	// reference choice and gain codes are the caller's; codes above 8h clip 700 mV
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		#1;
		reg_we_o = 1'b1;
		reg_addr_o = a;
		reg_wdata_o = d;
		@(posedge clk_i);
		#1;
		reg_we_o = 1'b0;
		reg_addr_o = ~a;
		reg_wdata_o = ~d;
		// external sample clock goes with the external clamp pulse
		if (a == 8'h1A && !d[1]) begin
			wr(8'h0F, 8'h80);
		end
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		#1;
		reg_re_o = 1'b1;
		reg_addr_o = a;
		@(posedge clk_i);
		#1;
		reg_re_o = 1'b0;
		reg_addr_o = ~a;
		d = reg_rdata_i;
	endtask
endmodule // igo_host_model

`default_nettype wire

/* File: sim/tb_top.sv */
/*
 * self-checking bench for the input route, gain and offset register group.
 * assumes igo_pkg, igo_regs and the host model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic reg_we_i, reg_re_i, vsync_o, hsync_o, ctrl_ref_ext_o;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, v;
	logic vsync_a_i = 1'b0;
	logic vsync_b_i = 1'b0;
	logic hsync_a_i = 1'b0;
	logic hsync_b_i = 1'b0;
	logic adc_valid_i = 1'b0;
	logic [1:0] sog_src_o, red_src_o, grn_src_o, blu_src_o, c;
	logic [3:0] g;
	igo_pkg::igo_sog_filt_t sog_filt_o;
	igo_pkg::igo_clp_filt_t clp_filt_o;
	igo_pkg::igo_route_t route_o;
	igo_pkg::igo_gain_t red_gain_o, grn_gain_o, blu_gain_o;
	logic [2:0][7:0] fine_hi_i = '0;
	logic [2:0][9:0] adc_data_i = '0;
	logic [2:0][9:0] out_data_o;
	logic [2:0] out_valid_o;
	int n_mismatch = 0;
	int samples_checked = 0;
	int cyc = 0;

	igo_regs dut_u (.clk_i, .srst_i, .reg_we_i, .reg_re_i, .reg_addr_i, .reg_wdata_i,
		.reg_rdata_o, .vsync_a_i, .vsync_b_i, .hsync_a_i, .hsync_b_i, .vsync_o, .hsync_o,
		.sog_src_o, .red_src_o, .grn_src_o, .blu_src_o, .sog_filt_o, .clp_filt_o, .route_o,
		.ctrl_ref_ext_o, .red_gain_o, .grn_gain_o, .blu_gain_o, .fine_hi_i, .adc_valid_i,
		.adc_data_i, .out_valid_o, .out_data_o);
	igo_host_model host_u (.clk_i, .reg_we_o(reg_we_i), .reg_re_o(reg_re_i),
		.reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o));

	// ==========================================
	// clock, timeout and reporting
	always #2.5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 6000) begin
			n_mismatch++;
			summarize();
		end
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		host_u.rd(a, v);
		check({8'h00, v}, {8'h00, exp});
	endtask

	task automatic settle();
		repeat (2) @(posedge clk_i);
		#1;
	endtask

	function automatic logic [9:0] ofs(input int adc, input int o);
		int s;
		s = adc + o - 512;
		return (s < 0) ? 10'h000 : (s > 1023) ? 10'h3FF : 10'(s);
	endfunction

	task automatic sample(input logic [2:0][9:0] d, input logic [2:0][7:0] hi);
		@(posedge clk_i);
		#1;
		adc_valid_i = 1'b1;
		adc_data_i = d;
		fine_hi_i = hi;
		@(posedge clk_i);
		#1;
		adc_valid_i = 1'b0;
		adc_data_i = ~d;
	endtask

	// ==========================================
	// tests
	initial begin
		repeat (20) @(posedge clk_i);
		#1;
		srst_i = 1'b0;
		rchk(igo_pkg::IGO_ADDR_INSEL, 8'h00);
		rchk(8'h1A, 8'hC2);
		rchk(8'h1B, 8'h77);
		rchk(8'h1C, 8'h07);
		rchk(8'h1D, 8'h00);
		rchk(8'h30, 8'h00);
		check(16'({sog_filt_o, clp_filt_o}), 16'h000C);
		check(16'(route_o), 16'h0001);
		check(16'(grn_gain_o), 16'h00EC);
		check(16'(blu_gain_o), 16'h00EC);
		check(16'(red_gain_o), 16'h00EC);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			c = 2'(i);
			host_u.wr(8'h1A, {c, c, c[0], c[1], c[0], c[1]});
			{vsync_a_i, vsync_b_i, hsync_a_i, hsync_b_i} = {c[0], ~c[0], ~c[0], c[0]};
			settle();
			rchk(8'h1A, {c, c, c[0], c[1], c[0], c[1]});
			check(16'(sog_filt_o), 16'(c));
			check(16'(clp_filt_o), (c == 2'h3) ? 16'h0002 : 16'(c));
			check(16'(route_o), 16'({c[0], c[1], c[1], c[0]}));
			check(16'(ctrl_ref_ext_o), 16'h0000);
			check(16'({vsync_o, hsync_o}), 16'({c[0] ^ c[1], ~(c[0] ^ c[1])}));
		end
		$display("test filter and clock done");
		for (int k = 0; k < 16; k += 5) begin
			g = 4'(k);
			host_u.wr(8'h1B, {g, ~g});
			host_u.wr(8'h1C, {~g, g});
			settle();
			rchk(8'h1B, {g, ~g});
			rchk(8'h1C, {4'h0, g});
			check(16'(grn_gain_o), 16'({g, 5'(g) + 5'h05}));
			check(16'(blu_gain_o), 16'({~g, {1'b0, ~g} + 5'h05}));
			check(16'(red_gain_o), 16'({g, 5'(g) + 5'h05}));
		end
		$display("test gain done");
		for (int i = 0; i < 4; i++) begin
			c = 2'(i);
			host_u.wr(igo_pkg::IGO_ADDR_INSEL, {c, c, c, c});
			settle();
			rchk(igo_pkg::IGO_ADDR_INSEL, {c, c, c, c});
			check(16'({sog_src_o, red_src_o, blu_src_o}), (c == 2'h3) ? 16'h002A : 16'({c, c, c}));
			check(16'(grn_src_o), 16'(c));
		end
		$display("test input select done");
		host_u.wr(8'h1D, 8'hF9);
		rchk(8'h1D, 8'h39);
		sample({10'h064, 10'h064, 10'h064}, {8'h80, 8'h80, 8'h80});
		check(16'(out_valid_o), 16'h0007);
		check(16'(out_data_o[2]), 16'(ofs(100, 515)));
		check(16'(out_data_o[1]), 16'(ofs(100, 514)));
		check(16'(out_data_o[0]), 16'(ofs(100, 513)));
		sample({10'h3E8, 10'h005, 10'h007}, {8'hFF, 8'h00, 8'h80});
		check(16'(out_data_o[2]), 16'(ofs(1000, 1023)));
		check(16'(out_data_o[1]), 16'(ofs(5, 2)));
		check(16'(out_data_o[0]), 16'(ofs(7, 513)));
		@(posedge clk_i);
		#1;
		check(16'(out_valid_o), 16'h0000);
		$display("test fine offset done");
		summarize();
	end
endmodule // tb_top

`default_nettype wire
